// file: include/tws_defs.svh
// constants for the two-wire slave engine
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_GC_ADDR     7'h00
`define TWS_OWN_RST     7'h00
`define TWS_BYTE_BITS   4'h8
`define TWS_LAST_SHIFT  4'h7
`define TWS_VSRC_SMR    8'h08
`define TWS_VSRC_CWG    8'h10
`define TWS_TXFREE_RST  1'b1
`define TWS_TRANSFER_COMPLETE_FLAG_RST  1'b1
`define TWS_PINS_IDLE   2'b11
`define TWS_LINE_IDLE   1'b1
`define TWS_L_ACT       7
`define TWS_L_RW        6
`define TWS_L_GC        5
`define TWS_L_HOLD      4
`define TWS_L_RX        3
`define TWS_L_TAKEN     2
`define TWS_L_ACKED     1
`define TWS_L_END       0
`define TWS_C_EN        2
`define TWS_C_THR       1
`define TWS_C_RD        0
`endif

// file: include/tws_pkg.sv
// types for the two-wire slave engine
package tws_pkg;
  typedef enum logic [3:0] {
    TWS_IDLE, TWS_ADDR, TWS_AACK, TWS_LOAD, TWS_TX,
    TWS_TACK, TWS_RX, TWS_RSTORE, TWS_RACK
  } tws_state_t;

  // state of the logic clocked by the link clock
  typedef struct packed {
    logic [1:0] s1, s2, s3;
    logic       sclF, sdaF;
    logic [2:0] c1, c2, c3, cF;
    tws_state_t state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic       active, rw, gcall, hold, nack;
    logic       tgRx, tgTaken, tgAcked, tgEnd;
    logic [7:0] rxByte;
    logic       sdaOe, sclOe, lowLevel;
  } tws_link_t;

  // state of the logic clocked by the system clock
  typedef struct packed {
    logic [7:0] l1, l2, l3, lF;
    logic       enabled, disArmed, thrTg, rdTg;
    logic [7:0] thrData, rhr;
    logic       txFree, rxFull, transfer_complete_flag, gcFlag, active, rw, waitSt, wpv;
    logic [7:0] vsrc;
    logic [6:0] ownAddr;
  } tws_host_t;
endpackage

// file: src/tws_slave.sv
// two-wire slave engine: link-side protocol and software-side flags
`timescale 1ns/10ps
`include "tws_defs.svh"

module tws_slave (
  // clocks and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       linkClk,
  // bus pins, open drain
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // software commands
  input  wire logic       slaveEnableCommand,
  input  wire logic       slaveDisableCommand,
  input  wire logic       writeProtectEnable,
  input  wire logic       ownAddrWrite,
  input  wire logic [6:0] ownAddrData,
  input  wire logic       cwgWrite,
  input  wire logic       thrWrite,
  input  wire logic [7:0] thrData,
  input  wire logic       rhrRead,
  input  wire logic       wpsrRead,
  // software status
  output logic [6:0]      ownSlaveAddress,
  output logic            slaveAccessActive,
  output logic            slaveReadDirection,
  output logic            generalCallSeen,
  output logic            transmitHoldingFree,
  output logic            receiveHoldingFull,
  output logic            transferCompleteFlag,
  output logic            clockWaitState,
  output logic            writeViolationFlag,
  output logic [7:0]      violationSourceField,
  output logic [7:0]      receiveHoldingRegister
);
  import tws_pkg::*;

  localparam tws_link_t LK_RESET = '{state: TWS_IDLE,
                                     s1: `TWS_PINS_IDLE, s2: `TWS_PINS_IDLE,
                                     s3: `TWS_PINS_IDLE, sclF: `TWS_LINE_IDLE,
                                     sdaF: `TWS_LINE_IDLE, default: '0};
  localparam tws_host_t HS_RESET = '{txFree: `TWS_TXFREE_RST,
                                     transfer_complete_flag: `TWS_TRANSFER_COMPLETE_FLAG_RST,
                                     ownAddr: `TWS_OWN_RST,
                                     default: '0};

  tws_link_t  lk, next_lk;
  tws_host_t  hs, next_hs;
  logic [7:0] pinF, c2lN, lN, ev, l2cVec;
  logic       sclN, sdaN, sclRise, sclFall, startSeen, stopSeen, linkEn;
  logic       thrAvail, rhrBusy, addrHit, gcHit, thrRoom, violate;

  // a change counts once the second and third stages agree
  function automatic logic [7:0] agree(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic [7:0] old);
    agree = (~(a ^ b) & b) | ((a ^ b) & old);
  endfunction

  // filtered pins, bus events and values seen from the system side
  assign pinF      = agree({6'h0, lk.s2}, {6'h0, lk.s3},
                           {6'h0, lk.sclF, lk.sdaF});
  assign sclN      = pinF[1];
  assign sdaN      = pinF[0];
  assign sclRise   = !lk.sclF && sclN;
  assign sclFall   = lk.sclF && !sclN;
  assign startSeen = lk.sclF && sclN && lk.sdaF && !sdaN;
  assign stopSeen  = lk.sclF && sclN && !lk.sdaF && sdaN;
  assign c2lN      = agree({5'h0, lk.c2}, {5'h0, lk.c3}, {5'h0, lk.cF});
  assign linkEn    = c2lN[`TWS_C_EN];
  assign thrAvail  = c2lN[`TWS_C_THR] != lk.tgTaken;
  assign rhrBusy   = c2lN[`TWS_C_RD] != lk.tgRx;
  // own address is quasi-static: it only changes while disabled or during a general-call access
  assign addrHit   = linkEn && (lk.shift[7:1] == hs.ownAddr);
  assign gcHit     = linkEn && (lk.shift[7:1] == `TWS_GC_ADDR)
                     && !lk.shift[0];

  // link-side protocol engine
  always_comb begin
    next_lk = lk;
    next_lk.s1 = {sclIn, sdaIn};
    next_lk.s2 = lk.s1;
    next_lk.s3 = lk.s2;
    next_lk.sclF = sclN;
    next_lk.sdaF = sdaN;
    next_lk.c1 = {hs.enabled, hs.thrTg, hs.rdTg};
    next_lk.c2 = lk.c1;
    next_lk.c3 = lk.c2;
    next_lk.cF = c2lN[2:0];
    next_lk.lowLevel = 1'b0;
    if (stopSeen) begin
      next_lk.state = TWS_IDLE;
      next_lk.sdaOe = 1'b0;
      next_lk.sclOe = 1'b0;
      next_lk.hold = 1'b0;
      if (lk.active) begin
        next_lk.active = 1'b0;
        next_lk.tgEnd = !lk.tgEnd;
      end
    end else if (startSeen) begin
      next_lk.state = TWS_ADDR;
      next_lk.cnt = 4'h0;
      next_lk.sdaOe = 1'b0;
      next_lk.sclOe = 1'b0;
      next_lk.hold = 1'b0;
    end else begin
      case (lk.state)
        TWS_ADDR: begin
          if (sclRise) begin
            next_lk.shift = {lk.shift[6:0], sdaN};
            next_lk.cnt = lk.cnt + 4'h1;
          end else if (sclFall && lk.cnt == `TWS_BYTE_BITS) begin
            if (addrHit || gcHit) begin
              next_lk.active = 1'b1;
              next_lk.rw = lk.shift[0];
              next_lk.gcall = gcHit;
              next_lk.sdaOe = 1'b1;
              next_lk.state = TWS_AACK;
            end else begin
              next_lk.state = TWS_IDLE;
              if (lk.active) begin
                next_lk.active = 1'b0;
                next_lk.tgEnd = !lk.tgEnd;
              end
            end
          end
        end
        TWS_AACK: begin
          if (sclFall) begin
            next_lk.sdaOe = 1'b0;
            next_lk.cnt = 4'h0;
            next_lk.state = lk.rw ? TWS_LOAD : TWS_RX;
          end
        end
        TWS_LOAD: begin
          if (thrAvail) begin
            next_lk.shift = hs.thrData;
            next_lk.tgTaken = !lk.tgTaken;
            next_lk.sdaOe = !hs.thrData[7];
            next_lk.sclOe = 1'b0;
            next_lk.hold = 1'b0;
            next_lk.cnt = 4'h0;
            next_lk.state = TWS_TX;
          end else begin
            next_lk.sclOe = 1'b1;
            next_lk.hold = 1'b1;
          end
        end
        TWS_TX: begin
          if (sclFall) begin
            if (lk.cnt == `TWS_LAST_SHIFT) begin
              next_lk.sdaOe = 1'b0;
              next_lk.state = TWS_TACK;
            end else begin
              next_lk.shift = {lk.shift[6:0], 1'b0};
              next_lk.sdaOe = !lk.shift[6];
              next_lk.cnt = lk.cnt + 4'h1;
            end
          end
        end
        TWS_TACK: begin
          if (sclRise) begin
            next_lk.nack = sdaN;
            next_lk.tgAcked = !lk.tgAcked;
          end else if (sclFall) begin
            next_lk.state = lk.nack ? TWS_IDLE : TWS_LOAD;
          end
        end
        TWS_RX: begin
          if (sclRise) begin
            next_lk.shift = {lk.shift[6:0], sdaN};
            next_lk.cnt = lk.cnt + 4'h1;
          end else if (sclFall && lk.cnt == `TWS_BYTE_BITS) begin
            next_lk.state = TWS_RSTORE;
          end
        end
        TWS_RSTORE: begin
          if (!rhrBusy) begin
            next_lk.rxByte = lk.shift;
            next_lk.tgRx = !lk.tgRx;
            next_lk.sdaOe = 1'b1;
            next_lk.sclOe = 1'b0;
            next_lk.hold = 1'b0;
            next_lk.state = TWS_RACK;
          end else begin
            next_lk.sclOe = 1'b1;
            next_lk.hold = 1'b1;
          end
        end
        TWS_RACK: begin
          if (sclFall) begin
            next_lk.sdaOe = 1'b0;
            next_lk.cnt = 4'h0;
            next_lk.state = TWS_RX;
          end
        end
        default: begin
          next_lk.state = TWS_IDLE;
        end
      endcase
    end
  end

  // link-side state register
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      lk <= LK_RESET;
    end else begin
      lk <= next_lk;
    end
  end

  // link-side values carried into the system domain
  assign l2cVec  = {lk.active, lk.rw, lk.gcall, lk.hold,
                    lk.tgRx, lk.tgTaken, lk.tgAcked, lk.tgEnd};
  assign lN      = agree(hs.l2, hs.l3, hs.lF);
  assign ev      = lN ^ hs.lF;
  assign thrRoom = hs.thrTg == lN[`TWS_L_TAKEN];
  assign violate = (ownAddrWrite || cwgWrite) && writeProtectEnable;

  // system-side flags and registers
  always_comb begin
    next_hs = hs;
    next_hs.l1 = l2cVec;
    next_hs.l2 = hs.l1;
    next_hs.l3 = hs.l2;
    next_hs.lF = lN;
    next_hs.active = lN[`TWS_L_ACT];
    if (lN[`TWS_L_ACT]) next_hs.rw = lN[`TWS_L_RW];
    next_hs.gcFlag = lN[`TWS_L_GC] && lN[`TWS_L_ACT];
    next_hs.waitSt = lN[`TWS_L_HOLD];
    if (slaveEnableCommand) begin
      next_hs.enabled = 1'b1;
      next_hs.disArmed = 1'b0;
    end else if (slaveDisableCommand) begin
      next_hs.enabled = 1'b0;
      next_hs.disArmed = 1'b1;
    end
    // transmit holding register and its free flag
    if (thrWrite && thrRoom) begin
      next_hs.thrData = thrData;
      next_hs.thrTg = !hs.thrTg;
      next_hs.txFree = 1'b0;
    end
    if (slaveEnableCommand && hs.disArmed) next_hs.txFree = 1'b0;
    if (ev[`TWS_L_TAKEN]) next_hs.txFree = 1'b0;
    if (ev[`TWS_L_ACKED]) next_hs.txFree = 1'b1;
    // receive holding register, set wins over read
    if (rhrRead && hs.rxFull) begin
      next_hs.rxFull = 1'b0;
      next_hs.rdTg = hs.lF[`TWS_L_RX];
    end
    if (ev[`TWS_L_RX]) begin
      next_hs.rhr = lk.rxByte;
      next_hs.rxFull = 1'b1;
    end
    // transfer complete: low during an access, set at its end
    if (ev[`TWS_L_ACT] && lN[`TWS_L_ACT]) next_hs.transfer_complete_flag = 1'b0;
    if (ev[`TWS_L_END]) next_hs.transfer_complete_flag = 1'b1;
    // own address and write protection
    if (ownAddrWrite && !writeProtectEnable
        && (!hs.enabled || hs.gcFlag)) begin
      next_hs.ownAddr = ownAddrData;
    end
    if (wpsrRead) next_hs.wpv = 1'b0;
    if (violate) begin
      next_hs.wpv = 1'b1;
      next_hs.vsrc = ownAddrWrite ? `TWS_VSRC_SMR : `TWS_VSRC_CWG;
    end
  end

  // system-side state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hs <= HS_RESET;
    end else begin
      hs <= next_hs;
    end
  end

  // outputs straight from state flip-flops
  assign sclOut                 = lk.lowLevel;
  assign sdaOut                 = lk.lowLevel;
  assign sclOe                  = lk.sclOe;
  assign sdaOe                  = lk.sdaOe;
  assign ownSlaveAddress        = hs.ownAddr;
  assign slaveAccessActive      = hs.active;
  assign slaveReadDirection     = hs.rw;
  assign generalCallSeen        = hs.gcFlag;
  assign transmitHoldingFree    = hs.txFree;
  assign receiveHoldingFull     = hs.rxFull;
  assign transferCompleteFlag   = hs.transfer_complete_flag;
  assign clockWaitState         = hs.waitSt;
  assign writeViolationFlag     = hs.wpv;
  assign violationSourceField   = hs.vsrc;
  assign receiveHoldingRegister = hs.rhr;

  // checks on the system side
  a_rx_set: assert property (@(posedge clk) disable iff (!reset_n)
    ev[`TWS_L_RX] |=> receiveHoldingFull ##0
      receiveHoldingRegister == $past(lk.rxByte))
    else $error("receive flag or data not taken");
  a_rx_clear: assert property (@(posedge clk) disable iff (!reset_n)
    rhrRead && receiveHoldingFull && !ev[`TWS_L_RX] |=> !receiveHoldingFull)
    else $error("receive flag not cleared by read");
  a_tx_acked: assert property (@(posedge clk) disable iff (!reset_n)
    ev[`TWS_L_ACKED] |=> transmitHoldingFree)
    else $error("transmit free not set after ack");
  a_tx_taken: assert property (@(posedge clk) disable iff (!reset_n)
    ev[`TWS_L_TAKEN] && !ev[`TWS_L_ACKED] |=> !transmitHoldingFree)
    else $error("transmit free not cleared on load");
  a_wp_block: assert property (@(posedge clk) disable iff (!reset_n)
    ownAddrWrite && writeProtectEnable |=> $stable(ownSlaveAddress)
      && writeViolationFlag && violationSourceField == `TWS_VSRC_SMR)
    else $error("protected address write not blocked");
  a_wp_cwg: assert property (@(posedge clk) disable iff (!reset_n)
    cwgWrite && !ownAddrWrite && writeProtectEnable |=>
      writeViolationFlag && violationSourceField == `TWS_VSRC_CWG)
    else $error("waveform violation not recorded");
  a_wp_clear: assert property (@(posedge clk) disable iff (!reset_n)
    wpsrRead && !violate |=> !writeViolationFlag)
    else $error("violation flag not cleared by read");
  a_addr_gate: assert property (@(posedge clk) disable iff (!reset_n)
    ownAddrWrite && hs.enabled && !generalCallSeen |=>
      $stable(ownSlaveAddress))
    else $error("own address changed while enabled");
  a_end_flag: assert property (@(posedge clk) disable iff (!reset_n)
    ev[`TWS_L_END] |=> transferCompleteFlag)
    else $error("transfer complete not set at end");

  // checks on the link side
  a_stop_drop: assert property (@(posedge linkClk) disable iff (!reset_n)
    stopSeen |=> !lk.active && !lk.sclOe && !lk.sdaOe)
    else $error("stop did not end the access");
  a_hold_scl: assert property (@(posedge linkClk) disable iff (!reset_n)
    lk.state == TWS_RSTORE && rhrBusy && !startSeen && !stopSeen
      |=> lk.sclOe && lk.hold)
    else $error("clock not held with receive register full");
endmodule

// file: tb/two_wire_slave_engine_tb_top.sv
// self-checking bench for the two-wire slave engine
`timescale 1ns/10ps
module two_wire_slave_engine_tb_top;
  localparam int EN = 0, DIS = 1, OAW = 2, CWG = 3, THR = 4, RHR = 5, WPS = 6;
  // clocks, reset and software side
  logic        clk, reset_n, linkClk, write_protect_enable, ack;
  logic [6:0]  cmd;
  logic [7:0]  swData, got, b;
  // bus pins, model pulls and resolved wires
  logic        sclOut, sclOe, sdaOut, sdaOe, mScl, mSda, stuck;
  wire         sclIn = !(mScl || (sclOe && !sclOut));
  wire         sdaIn = !(mSda || (sdaOe && !sdaOut));
  // status outputs
  logic [6:0]  own;
  logic        act, rdDir, gc, txFree, rxFull, transfer_complete_flag, waitSt, wpv;
  logic [7:0]  vsrc, rhr;
  // bookkeeping
  int          badCount = 0, totalChecks = 0;
  logic [31:0] seed = 32'h29e60836;
  logic [7:0]  expQ[$];

  tws_slave i_tws_slave (
    .clk(clk), .reset_n(reset_n), .linkClk(linkClk),
    .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .slaveEnableCommand(cmd[EN]), .slaveDisableCommand(cmd[DIS]),
    .writeProtectEnable(write_protect_enable), .ownAddrWrite(cmd[OAW]),
    .ownAddrData(swData[6:0]), .cwgWrite(cmd[CWG]), .thrWrite(cmd[THR]),
    .thrData(swData), .rhrRead(cmd[RHR]), .wpsrRead(cmd[WPS]),
    .ownSlaveAddress(own), .slaveAccessActive(act),
    .slaveReadDirection(rdDir), .generalCallSeen(gc),
    .transmitHoldingFree(txFree), .receiveHoldingFull(rxFull),
    .transferCompleteFlag(transfer_complete_flag), .clockWaitState(waitSt),
    .writeViolationFlag(wpv), .violationSourceField(vsrc),
    .receiveHoldingRegister(rhr));

  tws_bus_master i_tws_bus_master (
    .sclIn(sclIn), .sdaIn(sdaIn), .sclLow(mScl), .sdaLow(mSda),
    .stuck(stuck));

  // system clock and a free-running link clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #37;
    forever #80 linkClk = ~linkClk;
  end

  // xorshift source for data bytes
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // compare and count
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // one-cycle software pulse on command k with its data
  task automatic sw(input int k, input logic [7:0] d);
    @(posedge clk);
    cmd    <= 7'(1 << k);
    swData <= d;
    @(posedge clk);
    cmd <= '0;
    @(negedge clk);
  endtask

  // bounded wait for the wait-state flag to reach a level
  task automatic waitWs(input logic lvl);
    int n;
    n = 0;
    while (waitSt !== lvl && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) begin
      chk("wait state", 8'(lvl), 8'(waitSt));
      conclude();
    end
  endtask

  // the slave stretches; software serves it and the stretch must end
  task automatic serve(input int k, input logic [7:0] d);
    waitWs(1'b1);
    chk("clock held", 8'h01, 8'(sclOe));
    sw(k, d);
    waitWs(1'b0);
  endtask

  // software waits, bounded, for transfer complete before idling the unit
  task automatic waitDone();
    int n;
    n = 0;
    while (transfer_complete_flag !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      chk("transfer complete", 8'h01, 8'(transfer_complete_flag));
      conclude();
    end
  endtask

  // receive monitor: oldest note against each stored byte
  always @(posedge rxFull) begin
    @(negedge clk);
    if (expQ.size() == 0) chk("pending notes", 8'h01, 8'h00);
    else chk("received byte", expQ.pop_front(), rhr);
  end

  // a clock held beyond the model's bound, or a hung run
  always @(posedge stuck) begin
    chk("clock released", 8'h00, 8'h01);
    conclude();
  end
  initial begin
    #900000;
    chk("run finished", 8'h00, 8'h01);
    conclude();
  end

  initial begin
    {cmd, swData, write_protect_enable} = '0;
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("reset flags", 8'h60,
        {1'b0, txFree, transfer_complete_flag, act, gc, rxFull, waitSt, wpv});
    chk("reset address", 8'h00, {1'b0, own});
    done("reset");
    // address programming and write protection
    sw(OAW, 8'h2a);
    chk("own address", 8'h2a, {1'b0, own});
    @(posedge clk) write_protect_enable <= 1'b1;
    sw(OAW, 8'h11);
    chk("protected address", 8'h2a, {1'b0, own});
    chk("violation", 8'h88, {wpv, vsrc[6:0]});
    sw(CWG, 8'h00);
    chk("violation", 8'h90, {wpv, vsrc[6:0]});
    sw(WPS, 8'h00);
    chk("violation cleared", 8'h00, 8'(wpv));
    @(posedge clk) write_protect_enable <= 1'b0;
    sw(EN, 8'h00);
    sw(OAW, 8'h11);
    chk("enabled address", 8'h2a, {1'b0, own});
    done("protect");
    // master write, second byte arrives while the first is unread
    i_tws_bus_master.startCond();
    i_tws_bus_master.writeByte(8'h54, ack);
    chk("address ack", 8'h00, 8'(ack));
    chk("write access", 8'h04, {5'h0, act, rdDir, transfer_complete_flag});
    b = rnd();
    expQ.push_back(b);
    i_tws_bus_master.writeByte(b, ack);
    b = rnd();
    expQ.push_back(b);
    fork
      i_tws_bus_master.writeByte(b, ack);
      serve(RHR, 8'h00);
    join
    chk("data ack", 8'h00, 8'(ack));
    sw(RHR, 8'h00);
    chk("receive drained", 8'h00, 8'(rxFull));
    done("write");
    // repeated start reverses to read with the holding register empty
    b = rnd();
    i_tws_bus_master.startCond();
    fork
      begin
        i_tws_bus_master.writeByte(8'h55, ack);
        i_tws_bus_master.readByte(1'b1, got);
      end
      begin
        waitWs(1'b1);
        chk("reversal", 8'h06, {5'h0, act, rdDir, transfer_complete_flag});
        serve(THR, b);
      end
    join
    chk("read byte", b, got);
    chk("transmit free", 8'h01, 8'(txFree));
    b = rnd();
    sw(THR, b);
    chk("transmit taken", 8'h00, 8'(txFree));
    i_tws_bus_master.readByte(1'b0, got);
    chk("read byte", b, got);
    i_tws_bus_master.stopCond();
    waitDone();
    chk("end of access", 8'h01, {6'h0, act, transfer_complete_flag});
    done("reversal");
    // foreign address, general call, restart to a foreign address
    i_tws_bus_master.startCond();
    i_tws_bus_master.writeByte(8'haa, ack);
    chk("foreign address", 8'h02, {6'h0, ack, act});
    i_tws_bus_master.stopCond();
    i_tws_bus_master.startCond();
    i_tws_bus_master.writeByte(8'h00, ack);
    chk("general call", 8'h01, {6'h0, ack, gc});
    sw(OAW, 8'h33);
    chk("new address", 8'h33, {1'b0, own});
    b = rnd();
    expQ.push_back(b);
    i_tws_bus_master.writeByte(b, ack);
    sw(RHR, 8'h00);
    i_tws_bus_master.startCond();
    i_tws_bus_master.writeByte(8'haa, ack);
    chk("restart foreign", 8'h01, {6'h0, act, transfer_complete_flag});
    i_tws_bus_master.stopCond();
    waitDone();
    done("general call");
    // disable then enable clears the transmit-free flag
    sw(DIS, 8'h00);
    sw(EN, 8'h00);
    chk("transmit free cleared", 8'h00, 8'(txFree));
    done("reenable");
    chk("queue empty", 8'h00, 8'(expQ.size()));
    conclude();
  end
endmodule

// file: tb/tws_bus_master.sv
// open-drain bus master model that frames bytes for the slave engine
`timescale 1ns/10ps
module tws_bus_master #(
  parameter int QTR = 1000
) (
  // resolved wire levels
  input  wire logic sclIn,
  input  wire logic sdaIn,
  // pulls, high drags the wire low
  output logic      sclLow,
  output logic      sdaLow,
  // slave held the clock past the bound
  output logic      stuck
);
  // bus released at time zero, pull-ups keep both wires high
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    stuck  = 1'b0;
  end

  // release the clock, bounded wait while the slave stretches it
  task automatic sclHigh();
    int n;
    n = 0;
    sclLow = 1'b0;
    while (sclIn !== 1'b1 && n < 2000) begin
      #100;
      n++;
    end
    if (n >= 2000) stuck = 1'b1;
  endtask

  // one clock pulse; data changes only while the clock is low
  task automatic clkBit(input logic drive, output logic seen);
    sdaLow = !drive;
    #QTR;
    sclHigh();
    seen = sdaIn;
    #QTR;
    sclLow = 1'b1;
    #QTR;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic startCond();
    sdaLow = 1'b0;
    #QTR;
    sclHigh();
    #QTR;
    sdaLow = 1'b1;
    #QTR;
    sclLow = 1'b1;
    #QTR;
  endtask

  // stop: data rises while the clock is high, bus left idle
  task automatic stopCond();
    sdaLow = 1'b1;
    #QTR;
    sclHigh();
    #QTR;
    sdaLow = 1'b0;
    #QTR;
  endtask

  // eight bits msb first, then sample the slave's acknowledge
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clkBit(d[i], s);
    clkBit(1'b1, ack);
  endtask

  // eight bits from the slave, then acknowledge or not
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clkBit(1'b1, d[i]);
    clkBit(!ackIt, s);
  endtask
endmodule
